// [rtl/dma_write_command_handler.sv]
// Functional notes
// - Both 28-bit write opcodes start the command
// - Retry bit ignored, opcodes identical
// - Force-unit-access opcode starts 48-bit write
// - Payload arrives as 16-bit words
// - Every word gated by DMA request
// - One interrupt per command at end
// - Unrecoverable error stops at failing sector
// - Zero 8-bit count means 256 sectors
// - Sector number: sector or address 7:0
// - Cylinder bytes: cylinder or address 23:8
// - Head nibble: head or address 27:24
// - Sector count returns sectors not transferred
// - Registers return last transferred sector address, except the failing address after a 48-bit error
// - Force-unit-access flushes media before status unless a sector fails
// - 48-bit count from two writes, zero 65536
// - 48-bit address from six register bytes
// - 48-bit failing address readable, split by select
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module dma_write_command_handler (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// DMA data port
	output logic o_dmarq,
	input wire logic i_dma_wr,
	input wire logic [15:0] i_dma_word,
	// Interrupt
	output logic o_intrq,
	// Media side
	output logic o_media_word_valid,
	output logic [15:0] o_media_word,
	output logic o_sector_commit,
	output logic [47:0] o_sector_addr,
	output logic o_sector_lba,
	input wire logic i_media_done,
	input wire logic i_media_unrecoverable,
	output logic o_flush_req,
	input wire logic i_flush_done
);
	dma_write_pkg::state_t state;
	logic [7:0] count_cur, count_prev, snum_cur, snum_prev;
	logic [7:0] cyl_lo_cur, cyl_lo_prev, cyl_hi_cur, cyl_hi_prev;
	logic [7:0] dev_head, err_flags, dev_ctrl;
	logic status_err;
	logic is_ext;
	logic lba_mode;
	logic [47:0] cur_addr;
	logic [47:0] last_addr;
	logic [16:0] remaining;
	logic [8:0] word_cnt;
	logic [47:0] next_addr;
	logic [7:0] status_byte;
	logic busy;
	logic cmd_wr;
	logic tf_wr;
	localparam int DH_LBA_BIT_IDX = dma_write_pkg::DH_LBA_BIT;

	// Opcode decoding
	function automatic logic is_write28(input logic [7:0] op);
		return (op & dma_write_pkg::OP_RETRY_MASK) == dma_write_pkg::OP_WRITE_DMA;
	endfunction

	function automatic logic is_write48(input logic [7:0] op);
		return op == dma_write_pkg::OP_WRITE_DMA_FUA_EXT;
	endfunction

	assign busy = state != dma_write_pkg::ST_IDLE;
	assign cmd_wr = i_reg_wr && i_reg_addr == dma_write_pkg::OFF_STATUS_CMD && !busy;
	assign tf_wr = i_reg_wr && !busy;

	// Next sector address, LBA or CHS stepping
	always_comb begin
		next_addr = cur_addr;
		if (is_ext || lba_mode) begin
			next_addr = cur_addr + 48'h0000_0000_0001;
		end else if (cur_addr[7:0] != dma_write_pkg::SECTORS_PER_TRACK) begin
			next_addr[7:0] = cur_addr[7:0] + 8'h01;
		end else begin
			next_addr[7:0] = 8'h01;
			if (cur_addr[27:24] != dma_write_pkg::LAST_HEAD) begin
				next_addr[27:24] = cur_addr[27:24] + 4'h1;
			end else begin
				next_addr[27:24] = 4'h0;
				next_addr[23:8] = cur_addr[23:8] + 16'h0001;
			end
		end
	end

	// Command sequencer
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state <= dma_write_pkg::ST_IDLE;
		end else begin
			case (state)
				dma_write_pkg::ST_IDLE: begin
					if (cmd_wr) begin
						if (is_write28(i_reg_wdata) || is_write48(i_reg_wdata)) begin
							state <= dma_write_pkg::ST_XFER;
						end else begin
							state <= dma_write_pkg::ST_DONE;
						end
					end
				end
				dma_write_pkg::ST_XFER: begin
					if (i_dma_wr && word_cnt == dma_write_pkg::WORDS_PER_SECTOR - 9'h001) begin
						state <= dma_write_pkg::ST_COMMIT;
					end
				end
				dma_write_pkg::ST_COMMIT: begin
					if (i_media_done) begin
						if (i_media_unrecoverable) begin
							state <= dma_write_pkg::ST_DONE;
						end else if (remaining == 17'h0_0001) begin
							state <= is_ext ? dma_write_pkg::ST_FLUSH : dma_write_pkg::ST_DONE;
						end else begin
							state <= dma_write_pkg::ST_XFER;
						end
					end
				end
				dma_write_pkg::ST_FLUSH: begin
					if (i_flush_done) begin
						state <= dma_write_pkg::ST_DONE;
					end
				end
				dma_write_pkg::ST_DONE: begin
					state <= dma_write_pkg::ST_IDLE;
				end
				default: begin
					state <= dma_write_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Command parameters and progress
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			is_ext <= 1'b0;
			lba_mode <= 1'b0;
			cur_addr <= 48'h0000_0000_0000;
			last_addr <= 48'h0000_0000_0000;
			remaining <= 17'h0_0000;
		end else if (cmd_wr) begin
			is_ext <= is_write48(i_reg_wdata);
			lba_mode <= dev_head[DH_LBA_BIT_IDX];
			if (is_write48(i_reg_wdata)) begin
				cur_addr <= {cyl_hi_prev, cyl_lo_prev, snum_prev, cyl_hi_cur, cyl_lo_cur, snum_cur};
				last_addr <= {cyl_hi_prev, cyl_lo_prev, snum_prev, cyl_hi_cur, cyl_lo_cur, snum_cur};
				remaining <= {count_prev, count_cur} == 16'h0000 ?
					dma_write_pkg::MAX_COUNT_48 : {1'b0, count_prev, count_cur};
			end else begin
				cur_addr <= {20'h0_0000, dev_head[3:0], cyl_hi_cur, cyl_lo_cur, snum_cur};
				last_addr <= {20'h0_0000, dev_head[3:0], cyl_hi_cur, cyl_lo_cur, snum_cur};
				remaining <= count_cur == 8'h00 ?
					dma_write_pkg::MAX_COUNT_28 : {9'h000, count_cur};
			end
		end else if (state == dma_write_pkg::ST_COMMIT && i_media_done && !i_media_unrecoverable) begin
			last_addr <= cur_addr;
			remaining <= remaining - 17'h0_0001;
			if (remaining != 17'h0_0001) begin
				cur_addr <= next_addr;
			end
		end
	end

	// Word counter within a sector
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			word_cnt <= 9'h000;
		end else if (state != dma_write_pkg::ST_XFER) begin
			word_cnt <= 9'h000;
		end else if (i_dma_wr) begin
			word_cnt <= word_cnt + 9'h001;
		end
	end

	// request only while a sector is open
	assign o_dmarq = state == dma_write_pkg::ST_XFER;

	// Media word path
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_media_word_valid <= 1'b0;
			o_media_word <= 16'h0000;
		end else begin
			o_media_word_valid <= i_dma_wr && o_dmarq;
			if (i_dma_wr && o_dmarq) begin
				o_media_word <= i_dma_word;
			end
		end
	end

	// Sector commit and flush requests
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_sector_commit <= 1'b0;
			o_sector_addr <= 48'h0000_0000_0000;
			o_sector_lba <= 1'b0;
			o_flush_req <= 1'b0;
		end else begin
			o_sector_commit <= state == dma_write_pkg::ST_XFER && i_dma_wr &&
				word_cnt == dma_write_pkg::WORDS_PER_SECTOR - 9'h001;
			o_sector_addr <= cur_addr;
			o_sector_lba <= is_ext || lba_mode;
			// flush on entry to the flush wait
			o_flush_req <= state == dma_write_pkg::ST_COMMIT && i_media_done &&
				!i_media_unrecoverable && remaining == 17'h0_0001 && is_ext;
		end
	end

	// Task-file bytes and completion results
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			count_cur <= dma_write_pkg::RST_BYTE;
			count_prev <= dma_write_pkg::RST_BYTE;
			snum_cur <= dma_write_pkg::RST_BYTE;
			snum_prev <= dma_write_pkg::RST_BYTE;
			cyl_lo_cur <= dma_write_pkg::RST_BYTE;
			cyl_lo_prev <= dma_write_pkg::RST_BYTE;
			cyl_hi_cur <= dma_write_pkg::RST_BYTE;
			cyl_hi_prev <= dma_write_pkg::RST_BYTE;
			dev_head <= dma_write_pkg::RST_DEV_HEAD;
		end else if (state == dma_write_pkg::ST_DONE) begin
			count_cur <= remaining[7:0];
			count_prev <= remaining[15:8];
			if (is_ext) begin
				snum_cur <= cur_addr[7:0];
				cyl_lo_cur <= cur_addr[15:8];
				cyl_hi_cur <= cur_addr[23:16];
				snum_prev <= cur_addr[31:24];
				cyl_lo_prev <= cur_addr[39:32];
				cyl_hi_prev <= cur_addr[47:40];
			end else begin
				snum_cur <= last_addr[7:0];
				cyl_lo_cur <= last_addr[15:8];
				cyl_hi_cur <= last_addr[23:16];
				dev_head[3:0] <= last_addr[27:24];
			end
		end else if (tf_wr) begin
			case (i_reg_addr)
				dma_write_pkg::OFF_SECT_COUNT: begin
					count_prev <= count_cur;
					count_cur <= i_reg_wdata;
				end
				dma_write_pkg::OFF_SECT_NUM: begin
					snum_prev <= snum_cur;
					snum_cur <= i_reg_wdata;
				end
				dma_write_pkg::OFF_CYL_LOW: begin
					cyl_lo_prev <= cyl_lo_cur;
					cyl_lo_cur <= i_reg_wdata;
				end
				dma_write_pkg::OFF_CYL_HIGH: begin
					cyl_hi_prev <= cyl_hi_cur;
					cyl_hi_cur <= i_reg_wdata;
				end
				dma_write_pkg::OFF_DEV_HEAD: begin
					dev_head <= i_reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Device control byte
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			dev_ctrl <= dma_write_pkg::RST_BYTE;
		end else if (i_reg_wr && i_reg_addr == dma_write_pkg::OFF_DEV_CTRL) begin
			dev_ctrl <= i_reg_wdata;
		end
	end

	// Error cause and error status
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			err_flags <= dma_write_pkg::RST_BYTE;
			status_err <= 1'b0;
		end else if (cmd_wr) begin
			err_flags <= dma_write_pkg::RST_BYTE;
			status_err <= 1'b0;
			if (!is_write28(i_reg_wdata) && !is_write48(i_reg_wdata)) begin
				err_flags[dma_write_pkg::ER_ABORT] <= 1'b1;
				status_err <= 1'b1;
			end
		end else if (state == dma_write_pkg::ST_COMMIT && i_media_done && i_media_unrecoverable) begin
			err_flags[dma_write_pkg::ER_ID_NOT_FOUND] <= 1'b1;
			status_err <= 1'b1;
		end
	end

	// Interrupt line
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_intrq <= 1'b0;
		end else if (state == dma_write_pkg::ST_DONE) begin
			o_intrq <= 1'b1;
		end else if (cmd_wr || (i_reg_rd && i_reg_addr == dma_write_pkg::OFF_STATUS_CMD)) begin
			o_intrq <= 1'b0;
		end
	end

	// Status byte
	always_comb begin
		status_byte = 8'h00;
		status_byte[dma_write_pkg::ST_BUSY] = busy;
		status_byte[dma_write_pkg::ST_READY] = 1'b1;
		status_byte[dma_write_pkg::ST_SEEK_DONE] = 1'b1;
		status_byte[dma_write_pkg::ST_DATA_REQ] = o_dmarq;
		status_byte[dma_write_pkg::ST_ERR] = status_err;
	end

	// Read port, data one cycle later
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				dma_write_pkg::OFF_ERROR: o_reg_rdata <= err_flags;
				dma_write_pkg::OFF_SECT_COUNT: begin
					o_reg_rdata <= dev_ctrl[dma_write_pkg::CTRL_HOB_BIT] ? count_prev : count_cur;
				end
				dma_write_pkg::OFF_SECT_NUM: begin
					o_reg_rdata <= dev_ctrl[dma_write_pkg::CTRL_HOB_BIT] ? snum_prev : snum_cur;
				end
				dma_write_pkg::OFF_CYL_LOW: begin
					o_reg_rdata <= dev_ctrl[dma_write_pkg::CTRL_HOB_BIT] ? cyl_lo_prev : cyl_lo_cur;
				end
				dma_write_pkg::OFF_CYL_HIGH: begin
					o_reg_rdata <= dev_ctrl[dma_write_pkg::CTRL_HOB_BIT] ? cyl_hi_prev : cyl_hi_cur;
				end
				dma_write_pkg::OFF_DEV_HEAD: o_reg_rdata <= dev_head;
				dma_write_pkg::OFF_STATUS_CMD: o_reg_rdata <= status_byte;
				dma_write_pkg::OFF_DEV_CTRL: o_reg_rdata <= dev_ctrl;
				default: o_reg_rdata <= 8'h00;
			endcase
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end
endmodule // dma_write_command_handler
`default_nettype wire

// [rtl/dma_write_pkg.sv]
package dma_write_pkg;
	// Task-file register offsets
	localparam logic [3:0] OFF_DATA = 4'h0;
	localparam logic [3:0] OFF_ERROR = 4'h1;
	localparam logic [3:0] OFF_SECT_COUNT = 4'h2;
	localparam logic [3:0] OFF_SECT_NUM = 4'h3;
	localparam logic [3:0] OFF_CYL_LOW = 4'h4;
	localparam logic [3:0] OFF_CYL_HIGH = 4'h5;
	localparam logic [3:0] OFF_DEV_HEAD = 4'h6;
	localparam logic [3:0] OFF_STATUS_CMD = 4'h7;
	localparam logic [3:0] OFF_DEV_CTRL = 4'h8;
	// Opcodes
	localparam logic [7:0] OP_WRITE_DMA = 8'hCA;
	localparam logic [7:0] OP_RETRY_MASK = 8'hFE;
	localparam logic [7:0] OP_WRITE_DMA_FUA_EXT = 8'h3D;
	// Field positions
	localparam int DH_LBA_BIT = 6;
	localparam int CTRL_HOB_BIT = 7;
	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_SEEK_DONE = 4;
	localparam int ST_DATA_REQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_CRC = 7;
	localparam int ER_ID_NOT_FOUND = 4;
	localparam int ER_ABORT = 2;
	// Reset values
	localparam logic [7:0] RST_DEV_HEAD = 8'hA0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Counts
	localparam logic [8:0] WORDS_PER_SECTOR = 9'h100;
	localparam logic [16:0] MAX_COUNT_28 = 17'h0_0100;
	localparam logic [16:0] MAX_COUNT_48 = 17'h1_0000;
	// Drive geometry for CHS stepping
	localparam logic [7:0] SECTORS_PER_TRACK = 8'h3F;
	localparam logic [3:0] LAST_HEAD = 4'hF;
	typedef enum {
		ST_IDLE,
		ST_XFER,
		ST_COMMIT,
		ST_FLUSH,
		ST_DONE
	} state_t;
endpackage

// [test/dma_write_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module dma_write_assertions (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic i_reg_wr,
	// DMA and interrupt
	input wire logic o_dmarq,
	input wire logic i_dma_wr,
	input wire logic [15:0] i_dma_word,
	input wire logic o_intrq,
	// Media side
	input wire logic o_media_word_valid,
	input wire logic [15:0] o_media_word,
	input wire logic o_sector_commit,
	input wire logic i_media_done,
	input wire logic i_media_unrecoverable,
	input wire logic o_flush_req,
	input wire logic i_flush_done
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	property p_gate; i_dma_wr && !o_dmarq |=> !o_media_word_valid; endproperty
	a_gate: assert property (p_gate) else $error("word taken without request");
	property p_word; i_dma_wr && o_dmarq |=> o_media_word == $past(i_dma_word); endproperty
	a_word: assert property (p_word) else $error("word not passed whole");
	property p_commit; o_sector_commit |-> $past(o_dmarq) && $past(i_dma_wr); endproperty
	a_commit: assert property (p_commit) else $error("commit without last word");
	property p_pulse; o_sector_commit |=> !o_sector_commit; endproperty
	a_pulse: assert property (p_pulse) else $error("commit longer than a cycle");
	property p_stop; i_media_done && i_media_unrecoverable |=> !o_dmarq [*3]; endproperty
	a_stop: assert property (p_stop) else $error("transfer after failure");
	property p_flush; o_flush_req ##1 !i_flush_done |-> !o_intrq; endproperty
	a_flush: assert property (p_flush) else $error("interrupt before flush");
	property p_irq; o_intrq |-> !o_dmarq; endproperty
	a_irq: assert property (p_irq) else $error("interrupt during transfer");
	property p_new; i_reg_wr && i_reg_addr == 4'h7 && o_intrq |=> !o_intrq; endproperty
	a_new: assert property (p_new) else $error("interrupt kept by new command");
endmodule // dma_write_assertions
bind dma_write_command_handler dma_write_assertions u_chk (.i_ref_clk, .i_rst, .i_reg_addr,
	.i_reg_wr, .o_dmarq, .i_dma_wr, .i_dma_word, .o_intrq, .o_media_word_valid, .o_media_word,
	.o_sector_commit, .i_media_done, .i_media_unrecoverable, .o_flush_req, .i_flush_done);
`default_nettype wire

// [test/dma_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dma_host_model (
	// Clock and control
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_slow,
	// Device side
	input wire logic i_dmarq,
	output logic o_dma_wr,
	output logic [15:0] o_dma_word
);
	logic [7:0] cnt;
	always @(posedge i_ref_clk) begin
		o_dma_wr <= !i_rst && i_dmarq && !(o_dma_wr && (i_slow || cnt == 8'hFF));
		cnt <= i_rst ? 8'h00 : cnt + {7'h00, o_dma_wr && i_dmarq};
	end
	always @(posedge i_ref_clk) begin
		o_dma_word <= i_rst ? 16'h0000 : {o_dma_word[14:0], ~o_dma_word[15]};
	end
endmodule // dma_host_model
`default_nettype wire

// [test/dma_write_command_handler_test.sv]
`timescale 1ns/100ps
`default_nettype none
module dma_write_command_handler_test;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, slow = 1'b0;
	logic i_media_done = 1'b0, i_media_unrecoverable = 1'b0, i_flush_done = 1'b0;
	logic done_q = 1'b0, flush_q = 1'b0, i_dma_wr, o_dmarq, o_intrq, o_flush_req;
	logic o_media_word_valid, o_sector_commit, o_sector_lba;
	logic [3:0] i_reg_addr = 4'h0;
	logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
	logic [15:0] i_dma_word, o_media_word;
	logic [47:0] o_sector_addr;
	int n_fail = 0, comparisons = 0, sec = 0, fail_sec = -1, k;
	dma_write_command_handler dut (.i_ref_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
		.i_reg_rd, .o_reg_rdata, .o_dmarq, .i_dma_wr, .i_dma_word, .o_intrq, .o_media_word_valid,
		.o_media_word, .o_sector_commit, .o_sector_addr, .o_sector_lba, .i_media_done,
		.i_media_unrecoverable, .o_flush_req, .i_flush_done);
	dma_host_model host (.i_ref_clk, .i_rst, .i_slow(slow), .i_dmarq(o_dmarq),
		.o_dma_wr(i_dma_wr), .o_dma_word(i_dma_word));
	initial begin
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	// Media answers two cycles late
	always @(posedge i_ref_clk) begin
		done_q <= o_sector_commit;
		i_media_done <= done_q;
		i_media_unrecoverable <= done_q && sec == fail_sec;
		sec <= (i_reg_wr && i_reg_addr == 4'h7) ? 0 : sec + int'(done_q);
		flush_q <= o_flush_req;
		i_flush_done <= flush_q;
	end
	task end_sim;
		if (n_fail == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_reg_wr <= 1'b0;
	endtask
	task check(input logic [47:0] seen, input logic [47:0] want);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge i_ref_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_reg_rd <= 1'b0;
		#1;
		check(48'(o_reg_rdata & m), 48'(e));
	endtask
	task load(input logic [7:0] n, input logic [7:0] s, input logic [7:0] l,
		input logic [7:0] h, input logic [7:0] d);
		wr(4'h2, n);
		wr(4'h3, s);
		wr(4'h4, l);
		wr(4'h5, h);
		wr(4'h6, d);
	endtask
	task run(input logic [7:0] op, input int f);
		fail_sec = f;
		wr(4'h7, op);
		@(posedge i_ref_clk);
		#1;
		for (int i = 0; i < 9000 && o_intrq !== 1'b1; i++) #4;
		check(48'(o_intrq), 48'h0000_0000_0001);
	endtask
	initial begin
		#80000;
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rd(4'h7, 8'hFF, 8'h50);
		rd(4'h6, 8'hFF, 8'hA0);
		for (k = 0; k < 2; k++) begin
			slow <= k[0];
			load(8'h02, k ? 8'h01 : 8'hFF, 8'h34, 8'h12, k ? 8'hA2 : 8'hE5);
			run(k ? 8'hCB : dma_write_pkg::OP_WRITE_DMA, -1);
			rd(4'h7, 8'hFF, 8'h50);
			rd(4'h2, 8'hFF, 8'h00);
			rd(4'h3, 8'hFF, k ? 8'h02 : 8'h00);
			rd(4'h4, 8'hFF, k ? 8'h34 : 8'h35);
			rd(4'h5, 8'hFF, 8'h12);
			rd(4'h6, 8'h0F, k ? 8'h02 : 8'h05);
			check(o_sector_addr, k ? 48'h0000_0212_3402 : 48'h0000_0512_3500);
			check(48'(o_sector_lba), k ? 48'h0000_0000_0000 : 48'h0000_0000_0001);
		end
		slow <= 1'b0;
		load(8'h00, 8'hFF, 8'h34, 8'h12, 8'hE5);
		run(dma_write_pkg::OP_WRITE_DMA, 3);
		rd(4'h7, 8'hFF, 8'h51);
		rd(4'h1, 8'hFF, 8'h10);
		rd(4'h2, 8'hFF, 8'hFD);
		rd(4'h3, 8'hFF, 8'h01);
		rd(4'h4, 8'hFF, 8'h35);
		load(8'h00, 8'hC3, 8'hB2, 8'hA1, 8'h40);
		load(8'h00, 8'hF0, 8'hE5, 8'hD4, 8'h40);
		run(dma_write_pkg::OP_WRITE_DMA_FUA_EXT, 1);
		check(o_sector_addr, 48'hA1B2_C3D4_E5F1);
		rd(4'h3, 8'hFF, 8'hF1);
		rd(4'h4, 8'hFF, 8'hE5);
		rd(4'h5, 8'hFF, 8'hD4);
		wr(4'h8, 8'h80);
		rd(4'h2, 8'hFF, 8'hFF);
		rd(4'h3, 8'hFF, 8'hC3);
		rd(4'h4, 8'hFF, 8'hB2);
		rd(4'h5, 8'hFF, 8'hA1);
		wr(4'h8, 8'h00);
		load(8'h00, 8'h00, 8'h00, 8'h00, 8'h40);
		load(8'h01, 8'h10, 8'h00, 8'h00, 8'h40);
		run(dma_write_pkg::OP_WRITE_DMA_FUA_EXT, -1);
		rd(4'h7, 8'hFF, 8'h50);
		rd(4'h3, 8'hFF, 8'h10);
		run(8'hCC, -1);
		rd(4'h7, 8'hFF, 8'h51);
		rd(4'h1, 8'hFF, 8'h04);
		end_sim;
	end
endmodule // dma_write_command_handler_test
`default_nettype wire
